// File: rtl/pic_operation_command_three_pkg.sv
// constants for the command word three decode and trigger select block
package pic_operation_command_three_pkg;

    // =========================================================
    // i/o port addresses
    localparam logic [15:0] ADDR_CMD_MAIN  = 16'h0020;
    localparam logic [15:0] ADDR_CMD_CASC  = 16'h00A0;
    localparam logic [15:0] ADDR_TRIG_LOW  = 16'h04D0;
    localparam logic [15:0] ADDR_TRIG_HIGH = 16'h04D1;

    // =========================================================
    // command byte field positions
    localparam int OCW_SPECIAL_BIT    = 6;
    localparam int OCW_SPECIAL_EN_BIT = 5;
    localparam int OCW_INIT_BIT       = 4;
    localparam int OCW_SELECT_BIT     = 3;
    localparam int OCW_POLL_BIT       = 2;
    localparam int OCW_READ_CMD_BIT   = 1;
    localparam int OCW_READ_ISR_BIT   = 0;

    // poll answer byte layout
    localparam int POLL_PENDING_BIT   = 7;
    localparam int POLL_LEVEL_MSB     = 2;

    // =========================================================
    // reset and idle values
    localparam logic [7:0] TRIG_RESET    = 8'h00;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;
    localparam logic [7:0] BYTE_ZERO     = 8'h00;

    // status read selection, irr is the default after init
    typedef enum logic {
        SEL_IRR = 1'b0,
        SEL_ISR = 1'b1
    } read_sel_e;

endpackage

// File: rtl/pic_request_latch.sv
// request latch for eight inputs with edge or level triggering
`timescale 1ns/1ns

module pic_request_latch
    import pic_operation_command_three_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       nrst_i,
    input  wire logic       ce_i,
    input  wire logic       init_i,
    input  wire logic [7:0] line_i,
    input  wire logic [7:0] level_mode_i,
    input  wire logic [7:0] clear_i,
    output logic      [7:0] pending_o
);

    // =========================================================
    // previous line and trigger state for edge detection
    logic [7:0] line_prev;
    logic [7:0] mode_prev;

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            line_prev <= BYTE_ZERO;
            mode_prev <= TRIG_RESET;
        end else if (ce_i) begin
            line_prev <= line_i;
            mode_prev <= level_mode_i;
        end
    end

    // =========================================================
    // one latch per input
    genvar b;
    generate
        for (b = 0; b < 8; b++) begin : g_bit
            logic edge_set;
            logic false_set;
            // rising edge, or level to edge switch with line high
            assign edge_set  = line_i[b] & ~line_prev[b];
            assign false_set = mode_prev[b] & ~level_mode_i[b]
                               & line_i[b];

            // latch regardless of masking, set wins over clear
            always_ff @(posedge clk_i) begin
                if (!nrst_i) begin
                    pending_o[b] <= 1'b0;
                end else if (ce_i) begin
                    if (level_mode_i[b]) begin
                        pending_o[b] <= line_i[b];
                    end else if (edge_set || false_set) begin
                        pending_o[b] <= 1'b1;
                    end else if (init_i || clear_i[b]) begin
                        pending_o[b] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

endmodule // pic_request_latch

// File: rtl/pic_operation_command_three_and_edge_level_ctrl.sv
// command word three decode, status read select and trigger select
`timescale 1ns/1ns

module pic_operation_command_three_and_edge_level_ctrl
    import pic_operation_command_three_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        nrst_i,
    input  wire logic        ce_i,
    input  wire logic [15:0] io_addr_i,
    input  wire logic        io_wr_i,
    input  wire logic        io_rd_i,
    input  wire logic [7:0]  io_wdata_i,
    input  wire logic [15:0] irq_line_i,
    input  wire logic [15:0] irq_mask_i,
    input  wire logic [15:0] in_service_i,
    input  wire logic [15:0] req_clear_i,
    output logic      [7:0]  io_rdata_o,
    output logic      [15:0] request_pending_o,
    output logic      [15:0] level_mode_o,
    output logic      [1:0]  special_mask_o,
    output logic      [1:0]  poll_ack_o,
    output logic      [1:0]  init_seen_o
);

    // =========================================================
    // highest priority unmasked request, lowest index wins
    function automatic logic [3:0] prio_pick(input logic [7:0] req);
        logic [3:0] pick;
        pick = 4'h0;
        for (int i = 7; i >= 0; i--) begin
            if (req[i]) begin
                pick = {1'b1, i[2:0]};
            end
        end
        return pick;
    endfunction

    // =========================================================
    // address decode
    logic [1:0]      cmd_hit;
    logic [1:0]      cmd_wr;
    logic [1:0]      cmd_rd;
    logic [1:0]      init_pulse;
    logic [1:0][7:0] cmd_rdata;
    logic [1:0]      poll_take;
    logic            trig_low_hit;
    logic            trig_high_hit;

    assign cmd_hit[0]    = (io_addr_i == ADDR_CMD_MAIN);
    assign cmd_hit[1]    = (io_addr_i == ADDR_CMD_CASC);
    assign trig_low_hit  = (io_addr_i == ADDR_TRIG_LOW);
    assign trig_high_hit = (io_addr_i == ADDR_TRIG_HIGH);

    // =========================================================
    // trigger select registers
    logic [7:0] trig_low;
    logic [7:0] trig_high;

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            trig_low  <= TRIG_RESET;
            trig_high <= TRIG_RESET;
        end else if (ce_i && io_wr_i) begin
            if (trig_low_hit) begin
                trig_low <= io_wdata_i;
            end
            if (trig_high_hit) begin
                trig_high <= io_wdata_i;
            end
        end
    end

    // mode output mirrors the registers
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            level_mode_o <= {TRIG_RESET, TRIG_RESET};
        end else if (ce_i) begin
            level_mode_o <= {trig_high, trig_low};
        end
    end

    // =========================================================
    // per controller command decode and status read select
    genvar c;
    generate
        for (c = 0; c < 2; c++) begin : g_ctrl
            read_sel_e  rd_sel;
            logic       poll_armed;
            logic [7:0] stat_req;
            logic [7:0] stat_isr;
            logic [3:0] pick;
            logic       is_operation_command_three;

            assign cmd_wr[c]     = io_wr_i & cmd_hit[c];
            assign cmd_rd[c]     = io_rd_i & cmd_hit[c];
            // init word one decodes ahead of any operation word
            assign init_pulse[c] = cmd_wr[c]
                                   & io_wdata_i[OCW_INIT_BIT];
            assign is_operation_command_three       = cmd_wr[c]
                                   & ~io_wdata_i[OCW_INIT_BIT]
                                   & io_wdata_i[OCW_SELECT_BIT];
            assign stat_req      = request_pending_o[8*c +: 8];
            assign stat_isr      = in_service_i[8*c +: 8];
            assign pick          = prio_pick(stat_req
                                             & ~irq_mask_i[8*c +: 8]);
            assign poll_take[c]  = cmd_rd[c] & poll_armed;

            // status read selection kept until reselected, init word one returns it to irr
            always_ff @(posedge clk_i) begin
                if (!nrst_i) begin
                    rd_sel <= SEL_IRR;
                end else if (ce_i) begin
                    if (init_pulse[c]) begin
                        rd_sel <= SEL_IRR;
                    end else if (is_operation_command_three
                                 && io_wdata_i[OCW_READ_CMD_BIT]) begin
                        rd_sel <= io_wdata_i[OCW_READ_ISR_BIT]
                                  ? SEL_ISR : SEL_IRR;
                    end
                    // bit 1 clear holds the choice
                end
            end

            // special mask mode
            always_ff @(posedge clk_i) begin
                if (!nrst_i) begin
                    special_mask_o[c] <= 1'b0;
                end else if (ce_i) begin
                    if (init_pulse[c]) begin
                        special_mask_o[c] <= 1'b0;
                    end else if (is_operation_command_three
                                 && io_wdata_i[OCW_SPECIAL_EN_BIT]) begin
                        special_mask_o[c] <=
                            io_wdata_i[OCW_SPECIAL_BIT];
                    end
                end
            end

            // poll request armed until the next read, a write wins
            always_ff @(posedge clk_i) begin
                if (!nrst_i) begin
                    poll_armed <= 1'b0;
                end else if (ce_i) begin
                    if (init_pulse[c]) begin
                        poll_armed <= 1'b0;
                    end else if (is_operation_command_three) begin
                        poll_armed <= io_wdata_i[OCW_POLL_BIT];
                    end else if (poll_take[c]) begin
                        poll_armed <= 1'b0;
                    end
                end
            end

            // read data for this command port
            always_comb begin
                cmd_rdata[c] = BYTE_ZERO;
                if (poll_armed) begin
                    cmd_rdata[c][POLL_PENDING_BIT] = pick[3];
                    cmd_rdata[c][POLL_LEVEL_MSB:0] = pick[2:0];
                end else if (rd_sel == SEL_ISR) begin
                    cmd_rdata[c] = stat_isr;
                end else begin
                    cmd_rdata[c] = stat_req;
                end
            end

            // request latch of this controller
            pic_request_latch u_latch (
                .clk_i        (clk_i),
                .nrst_i       (nrst_i),
                .ce_i         (ce_i),
                .init_i       (init_pulse[c]),
                .line_i       (irq_line_i[8*c +: 8]),
                .level_mode_i (c == 0 ? trig_low : trig_high),
                .clear_i      (req_clear_i[8*c +: 8]),
                .pending_o    (request_pending_o[8*c +: 8])
            );
        end
    endgenerate

    // =========================================================
    // read data mux, registered
    logic [7:0] next_rdata;

    always_comb begin
        next_rdata = READ_UNMAPPED;
        if (cmd_hit[0]) begin
            next_rdata = cmd_rdata[0];
        end else if (cmd_hit[1]) begin
            next_rdata = cmd_rdata[1];
        end else if (trig_low_hit) begin
            next_rdata = trig_low;
        end else if (trig_high_hit) begin
            next_rdata = trig_high;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            io_rdata_o <= READ_UNMAPPED;
        end else if (ce_i && io_rd_i) begin
            io_rdata_o <= next_rdata;
        end
    end

    // =========================================================
    // poll acknowledge and init event pulses
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            poll_ack_o  <= 2'h0;
            init_seen_o <= 2'h0;
        end else if (ce_i) begin
            poll_ack_o  <= poll_take;
            init_seen_o <= init_pulse;
        end
    end

endmodule // pic_operation_command_three_and_edge_level_ctrl

// File: verification/pic_operation_command_three_properties.sv
// checker for command decode, special mask, poll and trigger select ports
`timescale 1ns/1ns

module pic_operation_command_three_props
    import pic_operation_command_three_pkg::*;
(
    input wire logic        clk_i,
    input wire logic        nrst_i,
    input wire logic        ce_i,
    input wire logic [15:0] io_addr_i,
    input wire logic        io_wr_i,
    input wire logic        io_rd_i,
    input wire logic [7:0]  io_wdata_i,
    input wire logic [15:0] irq_line_i,
    input wire logic [15:0] irq_mask_i,
    input wire logic [7:0]  io_rdata_o,
    input wire logic [15:0] request_pending_o,
    input wire logic [15:0] level_mode_o,
    input wire logic [1:0]  special_mask_o,
    input wire logic [1:0]  poll_ack_o,
    input wire logic [1:0]  init_seen_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    // =========================================================
    // accesses taken on the main controller and trigger ports
    wire wr_m  = ce_i && io_wr_i && io_addr_i == ADDR_CMD_MAIN;
    wire rd_m  = ce_i && io_rd_i && io_addr_i == ADDR_CMD_MAIN;
    wire wr_lo = ce_i && io_wr_i && io_addr_i == ADDR_TRIG_LOW;
    wire wr_hi = ce_i && io_wr_i && io_addr_i == ADDR_TRIG_HIGH;
    wire ocw_m = wr_m && io_wdata_i[4:3] == 2'b01;
    wire poll_any = |(request_pending_o[7:0] & ~irq_mask_i[7:0]);
    sequence poll_arm; ocw_m && io_wdata_i[2]; endsequence
    sequence poll_take; poll_arm ##2 rd_m; endsequence
    // =========================================================
    // properties
    trig_reset_a: assert property ($rose(nrst_i) |->
        level_mode_o == 16'h0000) else $error("trigger not cleared");
    trig_low_a: assert property (wr_lo |=> ##1
        level_mode_o[7:0] == $past(io_wdata_i, 2)) else $error("trig low");
    trig_high_a: assert property (wr_hi |=> ##1
        level_mode_o[15:8] == $past(io_wdata_i, 2)) else $error("trig high");
    init_pulse_a: assert property (wr_m && io_wdata_i[4] |=>
        init_seen_o == 2'b01 ##1 !init_seen_o[0]) else $error("init word");
    mask_load_a: assert property (ocw_m && io_wdata_i[5] |=>
        special_mask_o[0] == $past(io_wdata_i[6])) else $error("sm load");
    mask_keep_a: assert property (ocw_m && !io_wdata_i[5] |=>
        $stable(special_mask_o)) else $error("sm changed");
    poll_ack_a: assert property (poll_take |-> ##[1:2]
        poll_ack_o[0]) else $error("no poll ack");
    poll_flag_a: assert property (poll_take |=> io_rdata_o[7] ==
        $past(poll_any))
        else $error("poll flag");
    unmapped_rd_a: assert property (ce_i && io_rd_i &&
        io_addr_i == 16'h0100 |=> io_rdata_o == READ_UNMAPPED)
        else $error("unmapped read");
    level_follow_a: assert property ($past(level_mode_o[3]) &&
        level_mode_o[3] |-> request_pending_o[3] == $past(irq_line_i[3]))
        else $error("level follow");
    false_req_a: assert property ($fell(level_mode_o[3]) &&
        irq_line_i[3] |=> request_pending_o[3]) else $error("false req");
endmodule // pic_operation_command_three_props

bind pic_operation_command_three_and_edge_level_ctrl pic_operation_command_three_props u_props (.*);

// File: verification/pic_host_model.sv
// host model issuing byte reads and writes on the i/o bus
`timescale 1ns/1ns

module pic_host_model
    import pic_operation_command_three_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic [7:0]  io_rdata_i,
    output logic      [15:0] io_addr_o,
    output logic             io_wr_o,
    output logic             io_rd_o,
    output logic      [7:0]  io_wdata_o
);
    // idle bus at time zero
    initial begin
        io_addr_o = 16'hFFFF;
        io_wr_o = 1'b0;
        io_rd_o = 1'b0;
        io_wdata_o = 8'hFF;
    end
    // one write cycle, released lines show the inverse
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_i);
        io_addr_o <= a;
        io_wdata_o <= d;
        io_wr_o <= 1'b1;
        @(posedge clk_i);
        io_wr_o <= 1'b0;
        io_addr_o <= ~a;
        io_wdata_o <= ~d;
    endtask
    // one read cycle, data taken once settled
    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(posedge clk_i);
        io_addr_o <= a;
        io_rd_o <= 1'b1;
        @(posedge clk_i);
        io_rd_o <= 1'b0;
        io_addr_o <= ~a;
        @(negedge clk_i);
        d = io_rdata_i;
    endtask
    // command word three with select bits forced
    task automatic ocw(input logic [15:0] a, input logic [7:0] c);
        wr(a, {1'b0, c[6:5], 2'b01, c[2:0]});
    endtask
    // trigger write keeping inputs 0, 1, 2, 8, 13 on edge
    task automatic trig(input logic hi, input logic [7:0] d);
        wr(hi ? ADDR_TRIG_HIGH : ADDR_TRIG_LOW,
           d & (hi ? 8'hDE : 8'hF8));
    endtask
endmodule // pic_host_model

// File: verification/pic_operation_command_three_and_edge_level_ctrl_tb_top.sv
// testbench for command word three decode and trigger select
`timescale 1ns/1ns

module pic_operation_command_three_and_edge_level_ctrl_tb_top;
    import pic_operation_command_three_pkg::*;
    logic        clk_i, nrst_i, ce_i, wr, rd;
    logic [15:0] addr, line, mask, in_service_status, clr, pend, lvl;
    logic [7:0]  wdata, rdata;
    logic [1:0]  sm;
    int          mismatches = 0, tests_run = 0, cycles = 0;

    pic_operation_command_three_and_edge_level_ctrl DUT (.clk_i(clk_i), .nrst_i(nrst_i),
        .ce_i(ce_i), .io_addr_i(addr), .io_wr_i(wr), .io_rd_i(rd),
        .io_wdata_i(wdata), .irq_line_i(line), .irq_mask_i(mask),
        .in_service_i(in_service_status), .req_clear_i(clr), .io_rdata_o(rdata),
        .request_pending_o(pend), .level_mode_o(lvl),
        .special_mask_o(sm), .poll_ack_o(), .init_seen_o());
    pic_host_model u_host (.clk_i(clk_i), .io_rdata_i(rdata),
        .io_addr_o(addr), .io_wr_o(wr), .io_rd_o(rd), .io_wdata_o(wdata));

    // =========================================================
    // helpers
    task automatic chk(input string n, input logic [15:0] s, e);
        tests_run++;
        if (s !== e) begin
            mismatches++;
            $display("BAD %s exp %h seen %h", n, e, s);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
        @(negedge clk_i);
    endtask
    task automatic rdc(input logic [15:0] a, input logic [7:0] e,
                       input string n);
        logic [7:0] d;
        u_host.rd(a, d);
        chk(n, {8'h00, d}, {8'h00, e});
    endtask
    task automatic smc(input logic [7:0] c, input logic e);
        u_host.ocw(ADDR_CMD_MAIN, c);
        cyc(1);
        chk("special mask", {15'h0000, sm[0]}, {15'h0000, e});
    endtask
    task automatic print_verdict;
        $display("compares %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // clock and hang guard
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            mismatches++;
            print_verdict();
        end
    end

    // =========================================================
    // main sequence
    initial begin
        {nrst_i, line, mask, clr} = '0;
        ce_i = 1'b1;
        in_service_status = 16'h3CA5;
        repeat (5) @(posedge clk_i);
        nrst_i <= 1'b1;
        rdc(ADDR_TRIG_LOW, TRIG_RESET, "trig lo rst");
        rdc(ADDR_TRIG_HIGH, TRIG_RESET, "trig hi rst");
        rdc(16'h0100, READ_UNMAPPED, "unmapped");
        u_host.trig(1'b0, 8'h08);
        u_host.trig(1'b1, 8'h40);
        rdc(ADDR_TRIG_LOW, 8'h08, "trig lo");
        rdc(ADDR_TRIG_HIGH, 8'h40, "trig hi");
        chk("mode", lvl, 16'h4008);
        // a write with the clock enable low must be ignored
        @(posedge clk_i) ce_i <= 1'b0;
        u_host.trig(1'b1, 8'h80);
        @(posedge clk_i) ce_i <= 1'b1;
        rdc(ADDR_TRIG_HIGH, 8'h40, "frozen");
        @(posedge clk_i) line <= 16'h0018;
        @(posedge clk_i) line <= 16'h0008;
        cyc(2);
        chk("pending", pend, 16'h0018);
        u_host.ocw(ADDR_CMD_MAIN, 8'h0B);
        rdc(ADDR_CMD_MAIN, 8'hA5, "isr");
        rdc(ADDR_CMD_MAIN, 8'hA5, "isr again");
        u_host.ocw(ADDR_CMD_MAIN, 8'h09);
        rdc(ADDR_CMD_MAIN, 8'hA5, "isr kept");
        u_host.ocw(ADDR_CMD_MAIN, 8'h0A);
        rdc(ADDR_CMD_MAIN, 8'h18, "irr");
        u_host.ocw(ADDR_CMD_CASC, 8'h0B);
        rdc(ADDR_CMD_CASC, 8'h3C, "isr casc");
        smc(8'h68, 1'b1);
        smc(8'h48, 1'b1);
        chk("sm casc", {15'h0000, sm[1]}, 16'h0000);
        smc(8'h28, 1'b0);
        @(posedge clk_i) mask <= 16'h0008;
        u_host.ocw(ADDR_CMD_MAIN, 8'h0C);
        rdc(ADDR_CMD_MAIN, 8'h84, "poll");
        rdc(ADDR_CMD_MAIN, 8'h18, "poll once");
        @(posedge clk_i) clr <= 16'h0010;
        @(posedge clk_i) clr <= 16'h0000;
        cyc(1);
        chk("cleared", pend, 16'h0008);
        u_host.trig(1'b0, 8'h00);
        // clear lands on the switch edge, only the false request keeps it
        clr <= 16'h0008;
        @(posedge clk_i) clr <= 16'h0000;
        cyc(1);
        @(posedge clk_i) line <= 16'h0000;
        cyc(2);
        chk("false req", pend, 16'h0008);
        u_host.ocw(ADDR_CMD_MAIN, 8'h0C);
        rdc(ADDR_CMD_MAIN, 8'h00, "poll masked");
        @(posedge clk_i) mask <= 16'h0000;
        u_host.ocw(ADDR_CMD_MAIN, 8'h0C);
        rdc(ADDR_CMD_MAIN, 8'h83, "poll open");
        u_host.ocw(ADDR_CMD_MAIN, 8'h0B);
        u_host.wr(ADDR_CMD_MAIN, 8'h11);
        cyc(1);
        chk("reinit", pend, 16'h0000);
        rdc(ADDR_CMD_MAIN, 8'h00, "irr default");
        print_verdict();
    end
endmodule // pic_operation_command_three_and_edge_level_ctrl_tb_top
